// >>> lbs_pkg.sv
// package: opcode fields, status bit positions, timing constants
package lbs_pkg;
  localparam int unsigned LBS_DATA_W = 8;
  localparam int unsigned LBS_ADDR_W = 7;
  localparam int unsigned LBS_INSN_W = 14;
  localparam int unsigned LBS_OSC_PER_CYCLE = 4;
  // opcode patterns in the 14-bit instruction word
  localparam logic [5:0] LBS_OP_AND_LIT = 6'h39;
  localparam logic [5:0] LBS_OP_AND_FILE = 6'h05;
  localparam logic [3:0] LBS_OP_SKIP_CLR = 4'h6;
  localparam logic [3:0] LBS_OP_SKIP_SET = 4'h7;
  // field positions
  localparam int unsigned LBS_DEST_POS = 7;
  localparam int unsigned LBS_BIT_POS = 7;
  localparam int unsigned LBS_ZERO_POS = 2;
  // all ones, so the first AND after reset passes its operand through
  localparam logic [7:0] LBS_ACC_RESET = 8'hFF;
  localparam logic [7:0] LBS_STATUS_RESET = 8'h00;
  localparam logic [1:0] LBS_PHASE_LAST = 2'h3;
  typedef enum logic [1:0] {
    LBS_OP_NONE,
    LBS_OP_LIT,
    LBS_OP_FILE,
    LBS_OP_SKIP
  } lbs_op_t;
endpackage

// >>> lbs_decode.sv
// instruction word decoder for the four handled operations
`timescale 1ns/1ps
module lbs_decode
  import lbs_pkg::*;
(
  input wire logic [13:0] insn,
  output lbs_op_t op,
  output logic skip_on_set,
  output logic dest_file,
  output logic [6:0] addr,
  output logic [2:0] bit_sel,
  output logic [7:0] literal
);
  wire is_lit = insn[13:8] == LBS_OP_AND_LIT;
  wire is_file = insn[13:8] == LBS_OP_AND_FILE;
  wire is_skip = insn[13:10] == LBS_OP_SKIP_CLR ||
                 insn[13:10] == LBS_OP_SKIP_SET;
  assign op = is_lit ? LBS_OP_LIT : is_file ? LBS_OP_FILE :
              is_skip ? LBS_OP_SKIP : LBS_OP_NONE;
  assign skip_on_set = insn[13:10] == LBS_OP_SKIP_SET;
  assign dest_file = insn[LBS_DEST_POS];
  assign addr = insn[6:0];
  assign bit_sel = insn[LBS_BIT_POS +: 3];
  assign literal = insn[7:0];
endmodule

// >>> lbs_core.sv
// execution unit for AND and bit-test-skip operations
// Function
// - literal AND puts acc AND the 8-bit literal into acc; only Z changes.
// - register AND combines acc with file reg f (7-bit); only Z changes.
// - dest bit 0 sends the AND result to acc, 1 writes it to the file reg.
// - skip-when-set turns the next instruction into a no-op on bit 1.
// - skip-when-clear turns the next instruction into a no-op on bit 0.
// - neither bit-test skip changes any status flag.
// - a cycle is four clocks; a true test adds a second cycle as a no-op.
`timescale 1ns/1ps
module lbs_core
  import lbs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [13:0] INSN,
  input wire logic [7:0] FILE_RDATA,
  output logic [6:0] FILE_ADDR,
  output logic [7:0] FILE_WDATA,
  output logic FILE_WE,
  output logic [7:0] ACC,
  output logic ZERO_FLAG,
  output logic ZERO_WE,
  output logic INSN_DONE,
  output logic SKIP_NEXT,
  output logic NOP_CYCLE
);
  lbs_op_t op;
  logic skip_on_set;
  logic dest_file;
  logic [6:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] literal;

  lbs_decode u_dec (
    .insn(INSN),
    .op(op),
    .skip_on_set(skip_on_set),
    .dest_file(dest_file),
    .addr(addr),
    .bit_sel(bit_sel),
    .literal(literal)
  );

  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic squash_reg;
  logic squash_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic zero_reg;
  logic zero_next;
  logic [6:0] faddr_reg;
  logic [7:0] fwdata_reg;
  logic [7:0] fwdata_next;
  logic fwe_reg;
  logic fwe_next;
  logic zwe_reg;
  logic zwe_next;
  logic done_reg;
  logic skip_reg;
  logic skip_next;
  logic nop_reg;

  // zero test shared by both AND forms
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // execution happens on the last of the four clocks of a cycle
  wire exec = phase_reg == LBS_PHASE_LAST;
  wire live = exec && !squash_reg;
  wire [7:0] and_lit = acc_reg & literal;
  wire [7:0] and_file = acc_reg & FILE_RDATA;
  wire tested = FILE_RDATA[bit_sel];
  wire take_skip = (tested == skip_on_set);

  assign phase_next = phase_reg + 2'h1;

  always_comb begin
    acc_next = acc_reg;
    zero_next = zero_reg;
    fwdata_next = fwdata_reg;
    fwe_next = 1'b0;
    zwe_next = 1'b0;
    skip_next = 1'b0;
    squash_next = exec ? 1'b0 : squash_reg;
    if (live) begin
      unique case (op)
        LBS_OP_LIT: begin
          acc_next = and_lit;
          zero_next = is_zero(and_lit);
          zwe_next = 1'b1;
        end
        LBS_OP_FILE: begin
          zero_next = is_zero(and_file);
          zwe_next = 1'b1;
          if (dest_file) begin
            fwdata_next = and_file;
            fwe_next = 1'b1;
          end else begin
            acc_next = and_file;
          end
        end
        LBS_OP_SKIP: begin
          // flags untouched on both outcomes
          skip_next = take_skip;
          squash_next = take_skip;
        end
        LBS_OP_NONE: begin
          acc_next = acc_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // reset drops a pending squash, the next word runs normally
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      squash_reg <= 1'b0;
    end else begin
      squash_reg <= squash_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      acc_reg <= LBS_ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      zero_reg <= LBS_STATUS_RESET[LBS_ZERO_POS];
    end else begin
      zero_reg <= zero_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      faddr_reg <= 7'h00;
    end else begin
      faddr_reg <= addr;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      fwdata_reg <= 8'h00;
    end else begin
      fwdata_reg <= fwdata_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      fwe_reg <= 1'b0;
    end else begin
      fwe_reg <= fwe_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      zwe_reg <= 1'b0;
    end else begin
      zwe_reg <= zwe_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= exec;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= skip_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      nop_reg <= 1'b0;
    end else begin
      nop_reg <= exec && squash_reg;
    end
  end

  // address is registered so the file port sees a stable value
  assign FILE_ADDR = faddr_reg;
  assign FILE_WDATA = fwdata_reg;
  assign FILE_WE = fwe_reg;
  assign ACC = acc_reg;
  assign ZERO_FLAG = zero_reg;
  assign ZERO_WE = zwe_reg;
  assign INSN_DONE = done_reg;
  assign SKIP_NEXT = skip_reg;
  assign NOP_CYCLE = nop_reg;
endmodule

// >>> lbs_sva.sv
// assertions for the AND and bit-test-skip unit
`timescale 1ns/1ps
module lbs_sva
  import lbs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [13:0] INSN,
  input wire logic [7:0] FILE_RDATA,
  input wire logic FILE_WE,
  input wire logic [7:0] ACC,
  input wire logic ZERO_FLAG,
  input wire logic ZERO_WE,
  input wire logic INSN_DONE,
  input wire logic SKIP_NEXT,
  input wire logic NOP_CYCLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // squashed slot excluded, its word must not count
  wire logic run = INSN_DONE && !NOP_CYCLE;
  sequence s_gap;
    !INSN_DONE [*3] ##1 (INSN_DONE || NOP_CYCLE);
  endsequence
  a_lit_and: assert property (
    run && $past(INSN[13:8]) == LBS_OP_AND_LIT |->
    ACC == ($past(ACC) & $past(INSN[7:0])) && ZERO_WE &&
    ZERO_FLAG == (ACC == 8'h00)) else $error("literal and");
  a_file_dest: assert property (
    run && $past(INSN[13:8]) == LBS_OP_AND_FILE |->
    FILE_WE == $past(INSN[7]) && ZERO_WE) else $error("file and");
  a_skip_set: assert property (
    run && $past(INSN[13:10]) == LBS_OP_SKIP_SET |->
    SKIP_NEXT == $past(FILE_RDATA[INSN[9:7]])) else $error("skip set");
  a_skip_clr: assert property (
    run && $past(INSN[13:10]) == LBS_OP_SKIP_CLR |->
    SKIP_NEXT != $past(FILE_RDATA[INSN[9:7]])) else $error("skip clr");
  a_skip_quiet: assert property (
    SKIP_NEXT |-> !ZERO_WE && ZERO_FLAG == $past(ZERO_FLAG))
    else $error("skip flags");
  a_nop_slot: assert property (
    SKIP_NEXT |=> !INSN_DONE [*3] ##1 NOP_CYCLE && !ZERO_WE && !FILE_WE)
    else $error("nop slot");
  a_cycle_len: assert property (
    INSN_DONE |=> s_gap) else $error("cycle length");
endmodule
bind lbs_core lbs_sva u_sva (.CLK_SYS, .NRST, .INSN, .FILE_RDATA,
  .FILE_WE, .ACC, .ZERO_FLAG, .ZERO_WE, .INSN_DONE, .SKIP_NEXT, .NOP_CYCLE);

// >>> tb.sv
// self-checking bench for the AND and bit-test-skip unit
`timescale 1ns/1ps
module tb;
  import lbs_pkg::*;
  logic CLK_SYS, NRST, FILE_WE, ZERO_FLAG, ZERO_WE;
  logic INSN_DONE, SKIP_NEXT, NOP_CYCLE;
  logic [13:0] INSN;
  logic [7:0] FILE_RDATA, FILE_WDATA, ACC;
  logic [6:0] FILE_ADDR;
  int error_cnt = 0;
  int checked = 0;
  wire logic [7:0] flg = {2'h0, INSN_DONE, ZERO_FLAG, ZERO_WE, FILE_WE,
    SKIP_NEXT, NOP_CYCLE};
  lbs_core dut_u (.CLK_SYS, .NRST, .INSN, .FILE_RDATA, .FILE_ADDR,
    .FILE_WDATA, .FILE_WE, .ACC, .ZERO_FLAG, .ZERO_WE, .INSN_DONE,
    .SKIP_NEXT, .NOP_CYCLE);
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  // word held a full 4-clock cycle, result read after its last edge
  task automatic ex(input logic [13:0] i, input logic [7:0] d);
    INSN = i;
    FILE_RDATA = d;
    repeat (4) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic conclude;
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // acc leaves reset all ones, so the first AND shows its operand
  task automatic t_file;
    ex({LBS_OP_AND_FILE, 1'b1, 7'h55}, 8'h3C);
    chk(flg, 8'h2C);
    chk(FILE_WDATA, 8'h3C);
    chk({1'b0, FILE_ADDR}, 8'h55);
    chk(ACC, 8'hFF);
    ex({LBS_OP_AND_FILE, 1'b0, 7'h2A}, 8'hF0);
    chk(flg, 8'h28);
    chk(ACC, 8'hF0);
  endtask
  task automatic t_lit;
    ex({LBS_OP_AND_LIT, 8'hA5}, 8'h00);
    chk(ACC, 8'hA0);
    chk(flg, 8'h28);
    ex({LBS_OP_AND_LIT, 8'h0F}, 8'hFF);
    chk(ACC, 8'h00);
    chk(flg, 8'h38);
  endtask
  // reset lands while a skip is pending; the next word must still run
  task automatic t_reset;
    ex({LBS_OP_SKIP_SET, 3'h0, 7'h11}, 8'h01);
    chk(flg, 8'h32);
    NRST = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    NRST = 1'b1;
    chk(ACC, LBS_ACC_RESET);
    chk(flg, 8'h00);
    ex({LBS_OP_AND_LIT, 8'h5A}, 8'h00);
    chk(ACC, 8'h5A);
    chk(flg, 8'h28);
  endtask
  task automatic t_skip;
    logic [7:0] m;
    logic tk;
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 4; k++) begin
        m = 8'h01 << b;
        tk = k[0] == k[1];
        ex({k[1] ? LBS_OP_SKIP_SET : LBS_OP_SKIP_CLR, b[2:0], 7'h2A},
          k[0] ? m : ~m);
        chk(flg, {6'h0C, tk, 1'b0});
        if (tk) begin
          ex({LBS_OP_AND_FILE, 8'hFF}, 8'h00);
          chk(flg, 8'h31);
        end
      end
    end
  endtask
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  initial begin
    NRST = 1'b0;
    INSN = 14'h0000;
    FILE_RDATA = 8'h00;
    repeat (20) @(posedge CLK_SYS);
    #1;
    NRST = 1'b1;
    chk(flg, 8'h00);
    t_file();
    t_lit();
    t_skip();
    t_reset();
    conclude();
  end
endmodule
